// *** rtl/dpc_pkg.sv ***
package dpc_pkg;
    localparam int unsigned CLK_HZ      = 125_000_000;
    localparam int unsigned CLK_PER_NS  = 1_000_000_000 / CLK_HZ;
    localparam logic [31:0] DUTY_FULL   = 32'h0000_7D00;
    localparam logic [31:0] CLK_HZ_W    = 32'(CLK_HZ);
    localparam logic [31:0] ZERO_W      = 32'h0000_0000;

    // register byte offsets
    localparam logic [7:0] OFS_ACC1     = 8'h00;
    localparam logic [7:0] OFS_ACC2     = 8'h04;
    localparam logic [7:0] OFS_ACC3     = 8'h08;
    localparam logic [7:0] OFS_ACC4     = 8'h0C;
    localparam logic [7:0] OFS_PRESET1  = 8'h10;
    localparam logic [7:0] OFS_PRESET2  = 8'h14;
    localparam logic [7:0] OFS_DUTY1    = 8'h18;
    localparam logic [7:0] OFS_FREQ1    = 8'h1C;
    localparam logic [7:0] OFS_DUTY2    = 8'h20;
    localparam logic [7:0] OFS_FREQ2    = 8'h24;
    localparam logic [7:0] OFS_CTRL     = 8'h28;
    localparam logic [7:0] OFS_CNTCTL   = 8'h2C;
    localparam logic [7:0] OFS_OUTBITS  = 8'h30;
    localparam logic [7:0] OFS_SDUTY1   = 8'h34;
    localparam logic [7:0] OFS_SFREQ1   = 8'h38;
    localparam logic [7:0] OFS_SDUTY2   = 8'h3C;
    localparam logic [7:0] OFS_SFREQ2   = 8'h40;
    localparam logic [7:0] OFS_STATUS   = 8'h44;

    // control register fields: mode of channel i at [2i+1:2i], stop policy at STOPALT+i
    localparam int unsigned CTRL_MODE_W  = 2;
    localparam int unsigned CTRL_STOPALT = 4;
    localparam logic [31:0] CTRL_RST     = 32'h0000_0000;
    localparam int unsigned CNTCTL_W     = 4;
    localparam int unsigned NUM_CH       = 2;

    typedef enum logic [1:0] {
        DPC_MODE_NORMAL,
        DPC_MODE_PWM,
        DPC_MODE_CMP
    } dpc_mode_t;
endpackage

// *** rtl/dpc_pwm_if.sv ***
`timescale 1ns/1ns
interface dpc_pwm_if;
    logic [31:0] freq;
    logic [31:0] duty;
    logic        hold;
    logic        out;
    modport src (output freq, output duty, output hold, input out);
    modport gen (input freq, input duty, input hold, output out);
endinterface

// *** rtl/dpc_pwm_gen.sv ***
`timescale 1ns/1ns
module dpc_pwm_gen (
    input  wire logic hclk,      // system clock
    input  wire logic hresetn,   // async reset, active low
    dpc_pwm_if.gen    pif        // settings in, waveform out
);
    import dpc_pkg::*;

    logic [31:0] freq_r;
    logic [31:0] duty_r;
    logic [31:0] acc_r;
    logic        out_r;
    logic [32:0] sum;
    logic        wrap;
    logic [31:0] acc_nxt;
    logic        out_nxt;
    logic [63:0] lhs;
    logic [63:0] rhs;

    // phase accumulator: adds the frequency each cycle, wraps at the clock rate
    always_comb begin
        sum  = {1'b0, acc_r} + {1'b0, freq_r};
        wrap = sum >= {1'b0, CLK_HZ_W};
        if (freq_r >= CLK_HZ_W) begin
            acc_nxt = ZERO_W;
        end else if (wrap) begin
            acc_nxt = 32'(sum - {1'b0, CLK_HZ_W});
        end else begin
            acc_nxt = sum[31:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_r <= ZERO_W;
        end else if (pif.hold) begin
            acc_r <= acc_r;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    // new settings only at a period boundary, or at once while idle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            freq_r <= ZERO_W;
            duty_r <= ZERO_W;
        end else if (!pif.hold && (wrap || freq_r == ZERO_W || freq_r >= CLK_HZ_W)) begin
            freq_r <= pif.freq;
            duty_r <= pif.duty;
        end
    end

    // high while phase/clk < duty/full, compared by cross multiplication
    always_comb begin
        lhs = 64'(acc_r) * 64'(DUTY_FULL);
        rhs = 64'(duty_r) * 64'(CLK_HZ_W);
        if (duty_r == ZERO_W) begin
            out_nxt = 1'b0;
        end else if (duty_r >= DUTY_FULL) begin
            out_nxt = 1'b1;
        end else if (freq_r == ZERO_W) begin
            out_nxt = 1'b0;
        end else begin
            out_nxt = lhs < rhs;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_r <= 1'b0;
        end else if (!pif.hold) begin
            out_r <= out_nxt;
        end
    end

    assign pif.out = out_r;

    chk_zero_duty_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (!pif.hold && duty_r == ZERO_W) |=> !out_r)
        else $error("zero duty did not drive low");

    chk_full_duty_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (!pif.hold && duty_r >= DUTY_FULL) |=> out_r)
        else $error("full duty did not drive high");

    chk_setting_boundary: assert property (@(posedge hclk) disable iff (!hresetn)
        (freq_r != ZERO_W && freq_r < CLK_HZ_W && !wrap) |=> $stable(duty_r))
        else $error("duty changed inside a period");

    chk_phase_range: assert property (@(posedge hclk) disable iff (!hresetn)
        acc_r < CLK_HZ_W)
        else $error("phase accumulator out of range");
endmodule

// *** rtl/dpc_top.sv ***
// Register access over AHB-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
// Behaviour
// - two outputs, each independently set to normal, modulated or compare mode
// - normal mode: output follows its software output bit
// - compare mode: output i driven by counter i count against its preset
// - modulated mode: channel waveform drives the output, not the software bit
// - channels enabled separately, each with its own frequency and duty
// - duty 0 to 32000, high fraction equals duty over full scale
// - duty zero holds low, full scale holds high at any frequency
// - frequency is in hertz, period is its reciprocal
// - after reset or download, modulated output low until both settings written non-zero
// - stop mode: hold last state or use separate stop frequency and duty
// - stop frequency or stop duty zero keeps output low throughout stop
// - first or third control bit clears quadrature counter one or two
// - second or fourth control bit loads counter with counts per revolution less one
module dpc_top (
    input  wire logic        hclk,           // system clock, 125 MHz
    input  wire logic        hresetn,        // async reset, active low
    input  wire logic        hsel,           // slave select
    input  wire logic [31:0] haddr,          // byte address
    input  wire logic [1:0]  htrans,         // transfer type
    input  wire logic        hwrite,         // write when high
    input  wire logic [2:0]  hsize,          // transfer size
    input  wire logic [31:0] hwdata,         // write data
    input  wire logic        hready,         // bus ready in
    output logic      [31:0] hrdata,         // read data
    output logic             hreadyout,      // slave ready
    output logic             hresp,          // response, always okay
    input  wire logic [31:0] cnt_acc1,       // counter one accumulator
    input  wire logic [31:0] cnt_acc2,       // counter two accumulator
    input  wire logic [31:0] cnt_acc3,       // counter three accumulator
    input  wire logic [31:0] cnt_acc4,       // counter four accumulator
    input  wire logic        stop_mode,      // controller in stop mode
    input  wire logic        download_act,   // program download in progress
    output logic [3:0]       cnt_ctrl,       // counter clear and set controls
    output logic             output_one,     // dedicated output one
    output logic             output_two      // dedicated output two
);
    import dpc_pkg::*;

    dpc_pwm_if pwm_if [NUM_CH] ();

    logic [31:0]         preset_r  [NUM_CH];
    logic [31:0]         duty_r    [NUM_CH];
    logic [31:0]         freq_r    [NUM_CH];
    logic [31:0]         sduty_r   [NUM_CH];
    logic [31:0]         sfreq_r   [NUM_CH];
    logic [31:0]         ctrl_r;
    logic [CNTCTL_W-1:0] cntctl_r;
    logic [NUM_CH-1:0]   outbits_r;
    logic [NUM_CH-1:0]   armed_r;
    logic [NUM_CH-1:0]   duty_ok_r;
    logic [NUM_CH-1:0]   freq_ok_r;
    logic [NUM_CH-1:0]   drive_r;
    logic [NUM_CH-1:0]   drive_nxt;
    logic [NUM_CH-1:0]   cmp_hit;
    logic [31:0]         acc_cur   [NUM_CH];
    logic [7:0]          wr_addr_r;
    logic                wr_pend_r;
    logic [31:0]         rdata_r;
    logic [31:0]         rdata_nxt;
    logic                addr_ok;
    dpc_mode_t           mode      [NUM_CH];

    function automatic dpc_mode_t mode_of(input logic [31:0] ctrl, input int ch);
        logic [1:0] m;
        m = ctrl[ch*CTRL_MODE_W +: CTRL_MODE_W];
        if (m == 2'h1) begin
            return DPC_MODE_PWM;
        end else if (m == 2'h2) begin
            return DPC_MODE_CMP;
        end
        return DPC_MODE_NORMAL;
    endfunction

    function automatic logic is_wr(input logic [7:0] a, input logic [7:0] ofs);
        return wr_pend_r && (a == ofs);
    endfunction

    // ---------------- bus slave: zero wait, okay only
    assign addr_ok   = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = rdata_r;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= addr_ok && hwrite && (haddr[31:8] == 24'h00_0000);
            wr_addr_r <= haddr[7:0];
        end
    end

    always_comb begin
        rdata_nxt = ZERO_W;
        unique case (haddr[7:0])
            OFS_ACC1:    rdata_nxt = cnt_acc1;
            OFS_ACC2:    rdata_nxt = cnt_acc2;
            OFS_ACC3:    rdata_nxt = cnt_acc3;
            OFS_ACC4:    rdata_nxt = cnt_acc4;
            OFS_PRESET1: rdata_nxt = preset_r[0];
            OFS_PRESET2: rdata_nxt = preset_r[1];
            OFS_DUTY1:   rdata_nxt = duty_r[0];
            OFS_FREQ1:   rdata_nxt = freq_r[0];
            OFS_DUTY2:   rdata_nxt = duty_r[1];
            OFS_FREQ2:   rdata_nxt = freq_r[1];
            OFS_CTRL:    rdata_nxt = ctrl_r;
            OFS_CNTCTL:  rdata_nxt = 32'(cntctl_r);
            OFS_OUTBITS: rdata_nxt = 32'(outbits_r);
            OFS_SDUTY1:  rdata_nxt = sduty_r[0];
            OFS_SFREQ1:  rdata_nxt = sfreq_r[0];
            OFS_SDUTY2:  rdata_nxt = sduty_r[1];
            OFS_SFREQ2:  rdata_nxt = sfreq_r[1];
            OFS_STATUS:  rdata_nxt = 32'({stop_mode, armed_r, drive_r});
            default:     rdata_nxt = ZERO_W;
        endcase
        if (haddr[31:8] != 24'h00_0000) begin
            rdata_nxt = ZERO_W;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_r <= ZERO_W;
        end else if (addr_ok && !hwrite) begin
            rdata_r <= rdata_nxt;
        end
    end

    // ---------------- software registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            preset_r <= '{default: ZERO_W};
        end else begin
            if (is_wr(wr_addr_r, OFS_PRESET1)) preset_r[0] <= hwdata;
            if (is_wr(wr_addr_r, OFS_PRESET2)) preset_r[1] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            duty_r <= '{default: ZERO_W};
            freq_r <= '{default: ZERO_W};
        end else begin
            if (is_wr(wr_addr_r, OFS_DUTY1)) duty_r[0] <= hwdata;
            if (is_wr(wr_addr_r, OFS_FREQ1)) freq_r[0] <= hwdata;
            if (is_wr(wr_addr_r, OFS_DUTY2)) duty_r[1] <= hwdata;
            if (is_wr(wr_addr_r, OFS_FREQ2)) freq_r[1] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sduty_r <= '{default: ZERO_W};
            sfreq_r <= '{default: ZERO_W};
        end else begin
            if (is_wr(wr_addr_r, OFS_SDUTY1)) sduty_r[0] <= hwdata;
            if (is_wr(wr_addr_r, OFS_SFREQ1)) sfreq_r[0] <= hwdata;
            if (is_wr(wr_addr_r, OFS_SDUTY2)) sduty_r[1] <= hwdata;
            if (is_wr(wr_addr_r, OFS_SFREQ2)) sfreq_r[1] <= hwdata;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r    <= CTRL_RST;
            outbits_r <= '0;
        end else begin
            if (is_wr(wr_addr_r, OFS_CTRL)) ctrl_r <= hwdata;
            if (is_wr(wr_addr_r, OFS_OUTBITS)) outbits_r <= hwdata[NUM_CH-1:0];
        end
    end

    // counter controls are levels seen by the external counting logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cntctl_r <= '0;
        end else if (is_wr(wr_addr_r, OFS_CNTCTL)) begin
            cntctl_r <= hwdata[CNTCTL_W-1:0];
        end
    end

    assign cnt_ctrl = cntctl_r;

    // ---------------- channel setup
    assign acc_cur[0] = cnt_acc1;
    assign acc_cur[1] = cnt_acc2;

    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        localparam logic [7:0] DUTY_OFS = (i == 0) ? OFS_DUTY1 : OFS_DUTY2;
        localparam logic [7:0] FREQ_OFS = (i == 0) ? OFS_FREQ1 : OFS_FREQ2;
        logic                  stop_alt;
        logic                  pwm_off;
        assign mode[i]    = mode_of(ctrl_r, i);
        assign stop_alt   = ctrl_r[CTRL_STOPALT + i];
        // the generator takes new settings only at a wrap or while idle, so forced lows are applied here
        assign pwm_off    = download_act || !armed_r[i]
                            || (stop_mode && stop_alt
                                && (sfreq_r[i] == ZERO_W || sduty_r[i] == ZERO_W));
        assign cmp_hit[i] = acc_cur[i] >= preset_r[i];

        // each setting must be written non-zero after reset or a download
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                duty_ok_r[i] <= 1'b0;
                freq_ok_r[i] <= 1'b0;
            end else if (download_act) begin
                duty_ok_r[i] <= 1'b0;
                freq_ok_r[i] <= 1'b0;
            end else begin
                if (is_wr(wr_addr_r, DUTY_OFS) && hwdata != ZERO_W) begin
                    duty_ok_r[i] <= 1'b1;
                end
                if (is_wr(wr_addr_r, FREQ_OFS) && hwdata != ZERO_W) begin
                    freq_ok_r[i] <= 1'b1;
                end
            end
        end

        // armed once both settings were written non-zero; a download disarms
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                armed_r[i] <= 1'b0;
            end else if (download_act) begin
                armed_r[i] <= 1'b0;
            end else begin
                armed_r[i] <= duty_ok_r[i] && freq_ok_r[i];
            end
        end

        always_comb begin
            pwm_if[i].hold = 1'b0;
            pwm_if[i].freq = ZERO_W;
            pwm_if[i].duty = ZERO_W;
            if (mode[i] != DPC_MODE_PWM || download_act || !armed_r[i]) begin
                pwm_if[i].freq = ZERO_W;
                pwm_if[i].duty = ZERO_W;
            end else if (stop_mode && !stop_alt) begin
                pwm_if[i].hold = 1'b1;
                pwm_if[i].freq = freq_r[i];
                pwm_if[i].duty = duty_r[i];
            end else if (stop_mode) begin
                if (sfreq_r[i] != ZERO_W && sduty_r[i] != ZERO_W) begin
                    pwm_if[i].freq = sfreq_r[i];
                    pwm_if[i].duty = sduty_r[i];
                end
            end else begin
                pwm_if[i].freq = freq_r[i];
                pwm_if[i].duty = duty_r[i];
            end
        end

        dpc_pwm_gen u_gen (
            .hclk    (hclk),
            .hresetn (hresetn),
            .pif     (pwm_if[i].gen)
        );

        always_comb begin
            unique case (mode[i])
                DPC_MODE_NORMAL: drive_nxt[i] = outbits_r[i];
                DPC_MODE_PWM:    drive_nxt[i] = pwm_if[i].out && !pwm_off;
                DPC_MODE_CMP:    drive_nxt[i] = cmp_hit[i];
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            drive_r <= '0;
        end else begin
            drive_r <= drive_nxt;
        end
    end

    assign output_one = drive_r[0];
    assign output_two = drive_r[1];

    // ---------------- checks
    chk_normal_follows: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode[0] == DPC_MODE_NORMAL) |=> (output_one == $past(outbits_r[0])))
        else $error("normal output one not following its bit");

    chk_compare_two: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode[1] == DPC_MODE_CMP) |=> (output_two == $past(cnt_acc2 >= preset_r[1])))
        else $error("compare output two wrong");

    chk_compare_one: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode[0] == DPC_MODE_CMP) |=> (output_one == $past(cnt_acc1 >= preset_r[0])))
        else $error("compare output one wrong");

    chk_pwm_drives: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode[0] == DPC_MODE_PWM && armed_r[0] && !download_act && !stop_mode)
        |=> (output_one == $past(pwm_if[0].out)))
        else $error("modulated output one not from its generator");

    chk_download_disarms: assert property (@(posedge hclk) disable iff (!hresetn)
        download_act |=> (armed_r == '0))
        else $error("download did not disarm the channels");

    chk_stop_zero_one: assert property (@(posedge hclk) disable iff (!hresetn)
        (stop_mode && ctrl_r[CTRL_STOPALT] && sduty_r[0] == ZERO_W
         && mode[0] == DPC_MODE_PWM) |=> !output_one)
        else $error("stop with zero duty not low on output one");

    chk_unarmed_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (!armed_r[0] && mode[0] == DPC_MODE_PWM) [*3] |=> !output_one)
        else $error("unarmed modulated output one not low");

    chk_download_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (download_act && mode[1] == DPC_MODE_PWM) [*3] |=> !output_two)
        else $error("modulated output two not low in download");

    chk_stop_hold: assert property (@(posedge hclk) disable iff (!hresetn)
        (stop_mode && !ctrl_r[CTRL_STOPALT] && armed_r[0] && !download_act
         && mode[0] == DPC_MODE_PWM) [*3] |=> $stable(output_one))
        else $error("held output one changed in stop");

    chk_stop_zero_low: assert property (@(posedge hclk) disable iff (!hresetn)
        (stop_mode && ctrl_r[CTRL_STOPALT + 1] && sduty_r[1] == ZERO_W
         && mode[1] == DPC_MODE_PWM) [*3] |=> !output_two)
        else $error("stop with zero duty not low");

    chk_full_scale_on: assert property (@(posedge hclk) disable iff (!hresetn)
        (mode[0] == DPC_MODE_PWM && armed_r[0] && !stop_mode && !download_act
         && duty_r[0] == DUTY_FULL && freq_r[0] < CLK_HZ_W) [*8] |=> output_one)
        else $error("full scale duty not continuously high");

    chk_cnt_ctrl_write: assert property (@(posedge hclk) disable iff (!hresetn)
        is_wr(wr_addr_r, OFS_CNTCTL) |=> (cnt_ctrl == $past(hwdata[CNTCTL_W-1:0])))
        else $error("counter control not written");

    chk_okay_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout && !hresp)
        else $error("slave not ready or not okay");

    cov_pwm_one_toggles: cover property (@(posedge hclk) disable iff (!hresetn)
        mode[0] == DPC_MODE_PWM ##1 $rose(output_one) ##[1:1000] $fell(output_one));

    cov_compare_hit: cover property (@(posedge hclk) disable iff (!hresetn)
        mode[1] == DPC_MODE_CMP && $rose(output_two));

    cov_stop_alt: cover property (@(posedge hclk) disable iff (!hresetn)
        stop_mode && ctrl_r[CTRL_STOPALT] && armed_r[0] && $rose(output_one));

    cov_counter_set: cover property (@(posedge hclk) disable iff (!hresetn)
        $rose(cnt_ctrl[1]));

    cov_rearm: cover property (@(posedge hclk) disable iff (!hresetn)
        $fell(download_act) ##[1:1000] $rose(armed_r[0]));
endmodule

// *** testbench/dpc_load_model.sv ***
`timescale 1ns/1ns
// external load on the two outputs: tallies high cycles and rising edges since clr
module dpc_load_model (
    hclk,     // system clock
    clr,      // restart the tallies
    drv_one,  // line from output one
    drv_two,  // line from output two
    hi_one,   // cycles seen high on line one
    hi_two,   // cycles seen high on line two
    up_one,   // rising edges on line one
    up_two    // rising edges on line two
);
    input  wire logic        hclk;
    input  wire logic        clr;
    input  wire logic        drv_one;
    input  wire logic        drv_two;
    output logic      [15:0] hi_one;
    output logic      [15:0] hi_two;
    output logic      [15:0] up_one;
    output logic      [15:0] up_two;
    logic                    prev_one;
    logic                    prev_two;

    always @(posedge hclk) begin
        prev_one <= drv_one;
        prev_two <= drv_two;
        if (clr) begin
            hi_one <= 16'h0000;
            hi_two <= 16'h0000;
            up_one <= 16'h0000;
            up_two <= 16'h0000;
        end else begin
            hi_one <= hi_one + 16'(drv_one);
            hi_two <= hi_two + 16'(drv_two);
            up_one <= up_one + 16'(drv_one & ~prev_one);
            up_two <= up_two + 16'(drv_two & ~prev_two);
        end
    end
endmodule

// *** testbench/dpc_top_tb.sv ***
`timescale 1ns/1ns
`define CMP(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module dpc_top_tb;
    import dpc_pkg::*;
    logic        hclk, hresetn, hsel, hwrite, stop_mode, download_act;
    logic        pin_v, rd_dp, clr, hreadyout, hresp, output_one, output_two;
    logic [1:0]  htrans;
    logic [3:0]  cnt_ctrl;
    logic [31:0] haddr, hwdata, hrdata, pin_val, want, p1, p2;
    logic [31:0] acc [4];
    logic [15:0] hi_one, hi_two, up_one, up_two;
    logic [31:0] notes [$];
    int          miscompares, compares, cycles;
    integer      seed = 18227;

    initial begin
        hclk = 1'b0;
        forever #4 hclk = ~hclk;
    end

    dpc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .cnt_acc1(acc[0]), .cnt_acc2(acc[1]), .cnt_acc3(acc[2]), .cnt_acc4(acc[3]),
        .stop_mode(stop_mode), .download_act(download_act), .cnt_ctrl(cnt_ctrl),
        .output_one(output_one), .output_two(output_two));
    dpc_load_model u_load (.hclk(hclk), .clr(clr), .drv_one(output_one),
        .drv_two(output_two), .hi_one(hi_one), .hi_two(hi_two), .up_one(up_one),
        .up_two(up_two));

    task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
        hsel   <= 1'b1;
        haddr  <= {24'h00_0000, a};
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel   <= 1'b0;
        hwdata <= d;
        rd_dp  <= !w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rd_dp  <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        notes.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    task automatic pin(input logic [31:0] got, input logic [31:0] e);
        notes.push_back(e);
        pin_val <= got;
        pin_v   <= 1'b1;
        @(posedge hclk);
        pin_v   <= 1'b0;
        @(posedge hclk);
    endtask
    // settle, then tally n cycles of load activity
    task automatic meas(input int s, input int n);
        repeat (s) @(posedge hclk);
        clr <= 1'b1;
        @(posedge hclk);
        clr <= 1'b0;
        repeat (n) @(posedge hclk);
        #1;
    endtask
    function automatic logic [31:0] near(input int g, input int e, input int t);
        return ((g >= e - t) && (g <= e + t)) ? 32'h1 : 32'h0;
    endfunction
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic test_done();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        if (rd_dp && hreadyout) begin
            want = notes.pop_front();
            `CMP(hrdata, want)
        end
        if (pin_v) begin
            want = notes.pop_front();
            `CMP(pin_val, want)
        end
    end
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 40000) begin
            miscompares++;
            test_done();
        end
    end

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata} = '0;
        {stop_mode, download_act, pin_v, rd_dp, clr, pin_val} = '0;
        for (int i = 0; i < 4; i++) acc[i] = $random(seed);
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        for (int a = 16; a <= 68; a += 4) rd(8'(a), 32'h0000_0000);
        wr(8'h80, $random(seed));
        rd(8'h80, 32'h0000_0000);
        wr(OFS_ACC1, 32'hFFFF_FFFF);
        for (int i = 0; i < 4; i++) rd(8'(4 * i), acc[i]);
        note("registers");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_OUTBITS, {30'($random(seed)), 2'(i)});
            repeat (3) @(posedge hclk);
            pin({30'h0, output_two, output_one}, 32'(i));
        end
        note("normal");
        p1 = ($random(seed) & 32'h7FFF_FFFF) | 32'h1;
        p2 = ($random(seed) & 32'h7FFF_FFFF) | 32'h1;
        wr(OFS_PRESET1, p1);
        wr(OFS_PRESET2, p2);
        wr(OFS_CTRL, 32'h0000_000A);
        for (int k = 0; k < 2; k++) begin
            acc[0] <= p1 - 32'h1 + 32'(k);
            acc[1] <= p2 - 32'(k);
            repeat (3) @(posedge hclk);
            pin({30'h0, output_two, output_one}, k ? 32'h1 : 32'h2);
        end
        note("compare");
        wr(OFS_CTRL, 32'h0000_0005);
        wr(OFS_FREQ1, 32'd625_000);
        meas(50, 300);
        pin(32'(hi_one), 32'h0);
        wr(OFS_DUTY1, 32'd8_000);
        wr(OFS_DUTY2, 32'd16_000);
        wr(OFS_FREQ2, 32'd500_000);
        meas(300, 1000);
        pin(near(hi_one, 250, 3), 32'h1);
        pin(near(up_one, 5, 1), 32'h1);
        pin(near(hi_two, 500, 3), 32'h1);
        pin(near(up_two, 4, 1), 32'h1);
        wr(OFS_DUTY1, 32'h0000_0000);
        wr(OFS_DUTY2, DUTY_FULL);
        meas(300, 500);
        pin({hi_one, hi_two}, {16'd0, 16'd500});
        note("modulated");
        wr(OFS_DUTY1, 32'd16_000);
        wr(OFS_DUTY2, 32'd16_000);
        wr(OFS_CTRL, 32'h0000_0015);
        wr(OFS_SDUTY1, 32'd16_000);
        wr(OFS_SFREQ1, 32'd500_000);
        repeat (300) @(posedge hclk);
        stop_mode <= 1'b1;
        meas(300, 1000);
        pin(near(hi_one, 500, 3), 32'h1);
        pin(32'(up_two), 32'h0);
        wr(OFS_SDUTY1, 32'h0000_0000);
        meas(300, 500);
        pin(32'(hi_one), 32'h0);
        stop_mode <= 1'b0;
        note("stop");
        download_act <= 1'b1;
        meas(10, 200);
        pin({hi_one, hi_two}, 32'h0);
        download_act <= 1'b0;
        meas(300, 300);
        pin({hi_one, hi_two}, 32'h0);
        wr(OFS_DUTY1, 32'd16_000);
        wr(OFS_FREQ1, 32'd625_000);
        meas(300, 1000);
        pin(near(hi_one, 500, 3), 32'h1);
        note("download");
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CNTCTL, 32'h1 << i);
            repeat (2) @(posedge hclk);
            pin({28'h0, cnt_ctrl}, 32'h1 << i);
            rd(OFS_CNTCTL, 32'h1 << i);
        end
        wr(OFS_CNTCTL, 32'h0000_0000);
        note("counter controls");
        repeat (4) @(posedge hclk);
        test_done();
    end
endmodule
